// File: rtl/pvi_irq_unit.sv
/*
 * Prioritized vectored interrupt unit: pending flops, enable registers
 * on classic Wishbone, CPU global enable, and the take/CALL sequence.
 * Assumes source events are one-cycle pulses synchronous to clk, and a
 * CPU core that strobes instrDone at each instruction boundary and
 * answers takeIrq with irqAck once it is ready to be forced into CALL.
 */
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module pvi_irq_unit
    import pvi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // interrupt sources
    input  wire logic        se0,
    input  wire logic        tmr128Evt,
    input  wire logic        tmr1msEvt,
    input  wire logic [4:0]  epEvt,
    input  wire logic        dacEvt,
    input  wire logic        gpioEvt,
    input  wire logic        parallelHostPortEn,
    input  wire logic        parallelHostPortEvt,
    input  wire logic        serialEvt,
    // cpu core
    input  wire logic        instrDone,
    input  wire logic        irqAck,
    input  wire logic        disableIrqInstr,
    input  wire logic        enableIrqInstr,
    input  wire logic        returnFromIrqInstr,
    input  wire logic [13:0] pcIn,
    input  wire logic        carryFlag,
    input  wire logic        zeroFlag,
    input  wire logic [15:0] stackPopData,
    output logic             takeIrq,
    output logic [13:0]      irqVector,
    output logic             callBusy,
    output logic             stackPush,
    output logic [15:0]      stackPushData,
    output logic             pcLoad,
    output logic             restoreStrobe,
    output logic [13:0]      restorePc,
    output logic             restoreCarry,
    output logic             restoreZero,
    output logic             globalIrqSense,
    output logic             irqPendingSense
);

    // =====================================================================
    // state
    typedef struct packed {
        logic [7:0]         gieEn;
        logic [7:0]         epEn;
        logic [NUM_VEC-1:0] pending;
        logic               gie;
        pvi_state_t         state;
        logic [3:0]         idx;
        logic [3:0]         cnt;
        logic               ack;
        logic [31:0]        datO;
        logic               take;
        logic [13:0]        vector;
        logic               busy;
        logic               push;
        logic [15:0]        pushData;
        logic               load;
        logic               restore;
        logic [15:0]        restoreData;
        logic               pendSense;
    } pvi_main_t;

    localparam pvi_main_t RST_STATE = '{
        gieEn:       GIE_RST,
        epEn:        EP_RST,
        pending:     '0,
        gie:         1'b0,
        state:       ST_IDLE,
        idx:         4'h0,
        cnt:         4'h0,
        ack:         1'b0,
        datO:        32'h0000_0000,
        take:        1'b0,
        vector:      14'h0000,
        busy:        1'b0,
        push:        1'b0,
        pushData:    16'h0000,
        load:        1'b0,
        restore:     1'b0,
        restoreData: 16'h0000,
        pendSense:   1'b0
    };

    pvi_main_t          r;
    pvi_main_t          s;

    logic               busRstPulse;
    logic               gpioSrc;
    logic [NUM_VEC-1:0] setVec;
    logic [NUM_VEC-1:0] enVec;
    logic [NUM_VEC-1:0] reqVec;
    logic [NUM_VEC-1:0] clrVec;
    logic               anyReq;
    logic [3:0]         pickIdx;
    logic               wbReq;
    logic               wbWrite;
    logic [5:0]         regIdx;

    // =====================================================================
    // source shaping and priority
    pvi_se0_end u_se0_end (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .se0      (se0),
        .endPulse (busRstPulse)
    );

    pvi_prio_pick u_prio_pick (
        .req (reqVec),
        .any (anyReq),
        .idx (pickIdx)
    );

    // host port takes over the general pin slot entirely
    assign gpioSrc = parallelHostPortEn ? parallelHostPortEvt : gpioEvt;

    // slot order: bus reset, 128us, 1ms, A0, A1, A2, B0, B1, reserved,
    // analog, general, serial
    assign setVec = {serialEvt, gpioSrc, dacEvt, 1'b0, epEvt,
                     tmr1msEvt, tmr128Evt, busRstPulse};

    assign enVec = {r.gieEn[GIE_BIT_SERIAL],
                    r.gieEn[GIE_BIT_GPIO],
                    r.gieEn[GIE_BIT_DAC],
                    1'b0,
                    r.epEn[4:0],
                    r.gieEn[GIE_BIT_T1MS],
                    r.gieEn[GIE_BIT_T128],
                    r.gieEn[GIE_BIT_BUSRST]};

    assign reqVec = r.pending & enVec;

    // =====================================================================
    // bus decode
    assign wbReq   = cyc_i & stb_i & ~r.ack;
    // write lands on the edge where the master sees ack, not before
    assign wbWrite = cyc_i & stb_i & we_i & sel_i[0] & r.ack;
    assign regIdx  = adr_i[7:2];

    // =====================================================================
    // next state
    always_comb begin
        s         = r;
        clrVec    = '0;
        s.take    = 1'b0;
        s.push    = 1'b0;
        s.load    = 1'b0;
        s.restore = 1'b0;

        // one-cycle ack; unmapped reads return zero, writes dropped
        s.ack  = wbReq;
        s.datO = 32'h0000_0000;
        if (wbReq && !we_i) begin
            unique case (regIdx)
                IDX_GLOBAL_EN: s.datO[7:0] = r.gieEn;
                IDX_EP_EN:     s.datO[7:0] = r.epEn;
                IDX_CPU_STAT: begin
                    s.datO[STAT_BIT_GIE]  = r.gie;
                    s.datO[STAT_BIT_PEND] = |r.pending;
                end
                IDX_PENDING:   s.datO[NUM_VEC-1:0] = r.pending;
                default:       s.datO = 32'h0000_0000;
            endcase
        end
        if (wbWrite && regIdx == IDX_GLOBAL_EN) begin
            s.gieEn = dat_i[7:0] & GIE_WR_MASK;
        end
        if (wbWrite && regIdx == IDX_EP_EN) begin
            s.epEn = dat_i[7:0] & EP_WR_MASK;
        end

        // cpu global enable: DI and EI touch only this bit; RETURN_FROM_IRQ_INSTR also strobes the restore
        if (disableIrqInstr) begin
            s.gie = 1'b0;
        end
        if (enableIrqInstr) begin
            s.gie = 1'b1;
        end
        if (returnFromIrqInstr) begin
            s.gie         = 1'b1;
            s.restore     = 1'b1;
            s.restoreData = stackPopData;
        end

        unique case (r.state)
            ST_IDLE: begin
                // sampled only at a boundary, never mid instruction
                if (instrDone && r.gie && anyReq) begin
                    s.gie    = 1'b0; // first step of the take
                    s.take   = 1'b1;
                    s.idx    = pickIdx;
                    s.vector = pviVecAddr(pickIdx);
                    s.state  = ST_WAIT_ACK;
                end
            end
            ST_WAIT_ACK: begin
                if (irqAck) begin
                    clrVec   = NUM_VEC'(12'h001 << r.idx);
                    s.push   = 1'b1;
                    s.pushData = {zeroFlag, carryFlag, pcIn};
                    s.busy   = 1'b1;
                    s.cnt    = CALL_CYCLES - 4'h1;
                    s.state  = ST_CALL;
                end
            end
            ST_CALL: begin
                if (r.cnt == 4'h0) begin
                    s.busy  = 1'b0;
                    s.load  = 1'b1; // forced CALL lands on vector
                    s.state = ST_IDLE;
                end else begin
                    s.cnt = r.cnt - 4'h1;
                end
            end
            default: begin
                s.state = ST_IDLE;
            end
        endcase

        // set beats clear so an event in the clearing cycle survives;
        // masking never touches the flops
        s.pending   = (r.pending & ~clrVec) | setVec;
        s.pendSense = |s.pending;
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= RST_STATE; // enables cleared, all sources off
        end else if (ce) begin
            r <= s;
        end
    end

    // =====================================================================
    // outputs, all straight from flops
    assign ack_o           = r.ack;
    assign dat_o           = r.datO;
    assign takeIrq         = r.take;
    assign irqVector       = r.vector;
    assign callBusy        = r.busy;
    assign stackPush       = r.push;
    assign stackPushData   = r.pushData;
    assign pcLoad          = r.load;
    assign restoreStrobe   = r.restore;
    assign restorePc       = r.restoreData[13:0];
    assign restoreCarry    = r.restoreData[14];
    assign restoreZero     = r.restoreData[15];
    assign globalIrqSense  = r.gie;
    assign irqPendingSense = r.pendSense;

endmodule : pvi_irq_unit

// File: rtl/pvi_pkg.sv
/*
 * Shared constants, types and helpers for the prioritized vectored
 * interrupt unit: register indices, field positions, reset values,
 * vector layout and sequencing counts.
 * Assumes a classic Wishbone master with 32-bit data and a CPU core
 * that reports instruction boundaries and the DI, EI and RETURN_FROM_IRQ_INSTR
 * instructions as one-cycle strobes.
 */
package pvi_pkg;

    // =====================================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0]  IDX_GLOBAL_EN = 6'h20;
    localparam logic [5:0]  IDX_EP_EN     = 6'h21;
    localparam logic [5:0]  IDX_CPU_STAT  = 6'h22;
    localparam logic [5:0]  IDX_PENDING   = 6'h23;

    // =====================================================================
    // field layout and reset values
    localparam logic [7:0]  GIE_WR_MASK   = 8'h77;
    localparam logic [7:0]  EP_WR_MASK    = 8'h1F;
    localparam logic [7:0]  GIE_RST       = 8'h00;
    localparam logic [7:0]  EP_RST        = 8'h00;
    localparam int unsigned GIE_BIT_BUSRST = 0;
    localparam int unsigned GIE_BIT_T128   = 1;
    localparam int unsigned GIE_BIT_T1MS   = 2;
    localparam int unsigned GIE_BIT_DAC    = 4;
    localparam int unsigned GIE_BIT_GPIO   = 5;
    localparam int unsigned GIE_BIT_SERIAL = 6;
    localparam int unsigned STAT_BIT_GIE   = 2;
    localparam int unsigned STAT_BIT_PEND  = 7;

    // =====================================================================
    // vectors and sequencing
    localparam int unsigned NUM_VEC       = 12;
    localparam logic [13:0] VEC_BASE      = 14'h0002;
    localparam logic [3:0]  CALL_CYCLES   = 4'hA;
    localparam logic [3:0]  JMP_CYCLES    = 4'h5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_ACK,
        ST_CALL
    } pvi_state_t;

    // vector slot 0 is vector 1; slots two bytes apart
    function automatic logic [13:0] pviVecAddr(input logic [3:0] idx);
        pviVecAddr = VEC_BASE + {9'h000, idx, 1'b0};
    endfunction : pviVecAddr

endpackage : pvi_pkg

// File: rtl/pvi_se0_end.sv
/*
 * Bus reset event shaper: one-cycle pulse when a single-ended-zero
 * condition ends.
 * Assumes se0 is synchronous to clk and already qualified as a bus
 * reset by the receiver logic.
 */
`timescale 1ns/1ps
module pvi_se0_end
    import pvi_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic se0,
    output logic      endPulse
);

    // =====================================================================
    // state
    typedef struct packed {
        logic prev;
        logic pulse;
    } pvi_se0_t;

    pvi_se0_t r;
    pvi_se0_t s;

    always_comb begin
        s       = r;
        s.prev  = se0;
        s.pulse = r.prev & ~se0; // falling edge only
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= s;
        end
    end

    assign endPulse = r.pulse;

endmodule : pvi_se0_end

// File: rtl/pvi_prio_pick.sv
/*
 * Fixed-priority picker over the twelve vector slots.
 * Assumes slot 0 is vector 1 and slot 11 is vector 12.
 */
`timescale 1ns/1ps
module pvi_prio_pick
    import pvi_pkg::*;
(
    input  wire logic [NUM_VEC-1:0] req,
    output logic                    any,
    output logic [3:0]              idx
);

    // =====================================================================
    // lowest slot wins
    always_comb begin
        any = 1'b0;
        idx = 4'h0;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 4'(i); // lower number overrides
            end
        end
    end

endmodule : pvi_prio_pick

// File: bench/pvi_cpu_model.sv
/* CPU core partner for the interrupt unit: boundaries, take accept,
   stack frame echo and handler return.
   Assumes the unit drives takeIrq, pcLoad and stackPush as pulses. */
`timescale 1ns/1ps
module pvi_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        takeIrq,
    input  wire logic        pcLoad,
    input  wire logic        stackPush,
    input  wire logic [15:0] stackPushData,
    output logic             instrDone,
    output logic             irqAck,
    output logic             returnFromIrqInstr,
    output logic [13:0]      pcIn,
    output logic             carryFlag,
    output logic             zeroFlag,
    output logic [15:0]      stackPopData
);
    // =====================================================
    // behaviour
    int         ackWait = -1;
    int         retWait = -1;
    logic [1:0] beat;
    initial {instrDone, irqAck, returnFromIrqInstr, pcIn, carryFlag,
             zeroFlag, stackPopData, beat} = '0;
    always @(posedge clk) begin
        instrDone <= beat == 2'h3; // boundary every 4 cycles
        irqAck <= ackWait == 0; // accept take, slow or prompt
        returnFromIrqInstr <= retWait == 0; // handler done
        beat <= beat + 2'h1;
        ackWait <= takeIrq ? (slow ? 5 : 0) : ackWait - 1;
        retWait <= pcLoad ? 6 : retWait - 1;
        // flags move every cycle so a stale sample shows
        {zeroFlag, carryFlag, pcIn} <= {zeroFlag, carryFlag, pcIn} + 16'h1357;
        if (stackPush)
            stackPopData <= stackPushData; // frame returns
        if (rst) begin
            ackWait <= -1;
            retWait <= -1;
        end
    end
endmodule : pvi_cpu_model

// File: bench/pvi_irq_unit_properties.sv
/* Port assertions for the interrupt unit.
   Assumes one clock and ce held high. */
`timescale 1ns/1ps
module pvi_irq_unit_properties (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        instrDone,
    input wire logic        disableIrqInstr,
    input wire logic        enableIrqInstr,
    input wire logic        returnFromIrqInstr,
    input wire logic [13:0] pcIn,
    input wire logic        carryFlag,
    input wire logic        zeroFlag,
    input wire logic [15:0] stackPopData,
    input wire logic        tmr128Evt,
    input wire logic        takeIrq,
    input wire logic [13:0] irqVector,
    input wire logic        callBusy,
    input wire logic        stackPush,
    input wire logic [15:0] stackPushData,
    input wire logic        pcLoad,
    input wire logic        restoreStrobe,
    input wire logic [13:0] restorePc,
    input wire logic        restoreCarry,
    input wire logic        restoreZero,
    input wire logic        globalIrqSense,
    input wire logic        irqPendingSense
);
    // =====================================================
    // relations
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence callRun;
        callBusy [*5] ##1 callBusy [*5];
    endsequence
    a_take_at_boundary: assert property (takeIrq |-> $past(instrDone))
        else $error("take off boundary");
    a_take_when_idle: assert property (callBusy |-> !takeIrq)
        else $error("take during call");
    a_take_drops_gie: assert property (takeIrq |-> !globalIrqSense)
        else $error("gie kept on take");
    a_vector_in_table: assert property (takeIrq |->
        irqVector[0] == 1'h0 && irqVector != 14'h0012 &&
        irqVector inside {[14'h0002:14'h0018]})
        else $error("bad vector");
    a_call_length: assert property ($rose(callBusy) |->
        callRun ##1 (pcLoad && !callBusy))
        else $error("call length wrong");
    a_push_frame: assert property ($rose(callBusy) |-> stackPush &&
        stackPushData == {$past(zeroFlag), $past(carryFlag), $past(pcIn)})
        else $error("bad pushed frame");
    a_return_from_irq_instr_restores: assert property (returnFromIrqInstr &&
        !instrDone && !disableIrqInstr |=> restoreStrobe &&
        globalIrqSense &&
        {restoreZero, restoreCarry, restorePc} == $past(stackPopData))
        else $error("bad return");
    a_di_clears: assert property (disableIrqInstr &&
        !enableIrqInstr && !returnFromIrqInstr |=> !globalIrqSense)
        else $error("disable ignored");
    a_ei_sets: assert property (enableIrqInstr && !disableIrqInstr &&
        !instrDone |=> globalIrqSense)
        else $error("enable ignored");
    a_event_pending: assert property (tmr128Evt |=> irqPendingSense)
        else $error("pending not seen");
endmodule : pvi_irq_unit_properties

bind pvi_irq_unit pvi_irq_unit_properties chk_u (.clk, .rst, .instrDone,
    .disableIrqInstr, .enableIrqInstr, .returnFromIrqInstr, .pcIn,
    .carryFlag, .zeroFlag, .stackPopData, .tmr128Evt, .takeIrq, .irqVector,
    .callBusy, .stackPush, .stackPushData, .pcLoad, .restoreStrobe,
    .restorePc, .restoreCarry, .restoreZero, .globalIrqSense,
    .irqPendingSense);

// File: bench/prioritized_vectored_irq_unit_tb_top.sv
/* Bench for the interrupt unit: random event bursts, Wishbone register
   access, priority order and masking.
   Assumes the CPU partner model answers every take. */
`timescale 1ns/1ps
module prioritized_vectored_irq_unit_tb_top;
    import pvi_pkg::*;
    // =====================================================
    // signals
    logic        clk = '0, rst = '1, ce = '1, slow = '0, se0 = '0;
    logic        cyc_i = '0, stb_i = '0, we_i = '0, enableIrqInstr = '0;
    logic        tmr128Evt = '0, tmr1msEvt = '0, dacEvt = '0, gpioEvt = '0;
    logic        serialEvt = '0, parallelHostPortEn = '0;
    logic        parallelHostPortEvt = '0, disableIrqInstr = '0;
    logic [7:0]  adr_i = '0;
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = '0, dat_o;
    logic [4:0]  epEvt = '0;
    logic [13:0] irqVector, pcIn, restorePc;
    logic [15:0] stackPushData, stackPopData;
    logic        ack_o, takeIrq, callBusy, stackPush, pcLoad, restoreStrobe;
    logic        restoreCarry, restoreZero, globalIrqSense, irqPendingSense;
    logic        instrDone, irqAck, returnFromIrqInstr, carryFlag, zeroFlag;
    logic [13:0] vq[$];
    logic [31:0] seed = 32'h0000D716;
    int          errTotal = 0, numChecks = 0;

    pvi_irq_unit dut_u (.clk, .rst, .ce, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .se0, .tmr128Evt, .tmr1msEvt, .epEvt,
        .dacEvt, .gpioEvt, .parallelHostPortEn, .parallelHostPortEvt,
        .serialEvt, .instrDone, .irqAck, .disableIrqInstr, .enableIrqInstr,
        .returnFromIrqInstr, .pcIn, .carryFlag, .zeroFlag, .stackPopData,
        .takeIrq, .irqVector, .callBusy, .stackPush, .stackPushData, .pcLoad,
        .restoreStrobe, .restorePc, .restoreCarry, .restoreZero,
        .globalIrqSense, .irqPendingSense);
    pvi_cpu_model cpu_u (.clk, .rst, .slow, .takeIrq, .pcLoad, .stackPush,
        .stackPushData, .instrDone, .irqAck, .returnFromIrqInstr, .pcIn,
        .carryFlag, .zeroFlag, .stackPopData);

    always #4 clk = ~clk;
    always @(posedge clk)
        if (takeIrq === 1'h1)
            vq.push_back(irqVector);

    // =====================================================
    // helpers
    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nextRand
    // slot i serves vector i+1, two bytes per slot
    function automatic logic [31:0] expVec(input int slot);
        return 32'(VEC_BASE) + 32'(2 * slot);
    endfunction : expVec
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rdat);
        int n;
        n = 0;
        cyc_i <= '1;
        stb_i <= '1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk); while (ack_o !== 1'h1 && ++n < 50);
        if (n >= 50) begin
            errTotal++;
            summarize();
        end
        rdat = dat_o;
        cyc_i <= '0;
        stb_i <= '0;
        @(posedge clk);
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] got;
        wb(1'h0, a, 32'h0, got);
        chk(got, exp);
    endtask : rdc
    // gpio pulse rides along while the host port owns the slot
    task automatic fire(input logic [11:0] m);
        {se0, tmr128Evt, tmr1msEvt, epEvt, dacEvt, gpioEvt,
         parallelHostPortEvt, serialEvt} <= {m[0], m[1], m[2], m[7:3], m[9],
         m[10] | parallelHostPortEn, m[10] & parallelHostPortEn, m[11]};
        @(posedge clk);
        {se0, tmr128Evt, tmr1msEvt, epEvt, dacEvt, gpioEvt,
         parallelHostPortEvt, serialEvt} <= '0;
        repeat (4) @(posedge clk);
    endtask : fire
    task automatic summarize();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    // =====================================================
    // main sequence
    initial begin
        logic [31:0] q, r;
        logic [11:0] m, en, pend;
        int          cnt, n;
        pend = '0;
        repeat (2) @(posedge clk);
        rst <= '0;
        @(posedge clk);
        rdc(8'h80, 32'h0);
        rdc(8'h84, 32'h0);
        wb(1'h1, 8'h80, 32'hFF, r);
        rdc(8'h80, 32'h77);
        wb(1'h1, 8'h84, 32'hFF, r);
        rdc(8'h84, 32'h1F);
        wb(1'h1, 8'hFC, 32'hFF, r);
        rdc(8'hFC, 32'h0);
        for (int k = 0; k < 24; k++) begin
            q = nextRand();
            m = q[11:0] & 12'hEFF;
            disableIrqInstr <= '1;
            slow <= q[12];
            parallelHostPortEn <= q[13];
            @(posedge clk);
            disableIrqInstr <= '0;
            fire(m);
            pend |= m;
            rdc(8'h8C, {20'h0, pend});
            rdc(8'h88, {24'h0, |pend, 7'h0});
            q = nextRand();
            en = {q[6:4], 1'h0, q[12:8], q[2:0]};
            wb(1'h1, 8'h80, q, r);
            wb(1'h1, 8'h84, q >> 8, r);
            cnt = $countones(pend & en);
            vq.delete();
            enableIrqInstr <= '1;
            @(posedge clk);
            enableIrqInstr <= '0;
            n = 0;
            while ((vq.size() < cnt || globalIrqSense !== 1'h1 ||
                    callBusy !== 1'h0) && n++ < 3000)
                @(posedge clk);
            if (n > 3000) begin
                errTotal++;
                summarize();
            end
            chk(32'(vq.size()), 32'(cnt));
            for (int i = 0; i < 12; i++)
                if (pend[i] & en[i])
                    chk(32'(vq.pop_front()), expVec(i));
            pend &= ~en;
            rdc(8'h8C, {20'h0, pend});
            rdc(8'h88, {24'h0, |pend, 4'h0, 1'h1, 2'h0});
        end
        // mid-run reset with enables set and flags pending
        disableIrqInstr <= '1;
        @(posedge clk);
        disableIrqInstr <= '0;
        wb(1'h1, 8'h80, 32'hFF, r);
        wb(1'h1, 8'h84, 32'hFF, r);
        fire(12'h002);
        rst <= '1;
        repeat (2) @(posedge clk);
        rst <= '0;
        @(posedge clk);
        rdc(8'h80, 32'h0);
        rdc(8'h84, 32'h0);
        rdc(8'h8C, 32'h0);
        rdc(8'h88, 32'h0);
        summarize();
    end

    initial begin
        #400000;
        errTotal++;
        summarize();
    end
endmodule : prioritized_vectored_irq_unit_tb_top
